// ### sfdp_map.vh
`ifndef SFDP_MAP_VH
`define SFDP_MAP_VH
// Register indices as printed; the byte address is four times the index.
`define SFDP_IDX_CTRL      10'h01F
`define SFDP_IDX_SKEW      10'h055
`define SFDP_IDX_SYNCFIFO  10'h0E9
`define SFDP_IDX_RECEIVE_FEATURE_CONFIG     10'h134
`define SFDP_IDX_MUX1      10'h171
`define SFDP_IDX_MUX2      10'h172
`define SFDP_IDX_PHASE     10'h180
`define SFDP_IDX_STATUS    10'h181
`define SFDP_SYNC_MAGIC    16'hDF22
`define SFDP_BIT_RESTART   14
`define SFDP_BIT_EXTMAC    7
`define SFDP_RST_16        16'h0000
`define SFDP_STEP_NS       8
`define SFDP_CLK_NS        40
`define SFDP_SKEW_MS_HI    7
`define SFDP_SKEW_MS_LO    4
`define SFDP_SKEW_SL_HI    3
`define SFDP_SKEW_SL_LO    0
`define SFDP_MUX_W         4
`define SFDP_PINS          4
`define SFDP_SEL_NONE      4'h0
`define SFDP_SEL_TX        4'h1
`define SFDP_SEL_RX        4'h2
`define SFDP_RESP_OKAY     2'b00
`define SFDP_RESP_SLVERR   2'b10
`endif

// ### sfdp_top.v
// Register access over AXI4-Lite was left to the implementer.
`timescale 1ns/1ns
// Overview of operation
// - Pulse on every transmit and receive delimiter; a delimiter that comes while a delayed pulse is pending cancels that pulse.
// - Transmit at line placement, receive at first symbol.
// - Phase register shifts pulse in 8 ns steps; here rounded up to whole 40 ns clock cycles.
// - Two mux registers route pulses to pins.
// - Pins stay quiet unless extended MAC bit set.
// - Receive pulse delayed by pair alignment amount.
// - Added delay fixed through one uninterrupted link.
// - Restart bit re-establishes an existing link.
// - Master mode skew reported in bits 7:4.
// - Slave mode skew reported in bits 3:0.
// - Skew valid only after setup then new link.
// - No skew readout needed at 100 Mb.
`include "sfdp_map.vh"
module sfdp_top (
   input  wire        clk_sys,
   input  wire        resetn,
   input  wire        clk_en,
   input  wire [11:0] s_axi_awaddr,
   input  wire        s_axi_awvalid,
   output wire        s_axi_awready,
   input  wire [31:0] s_axi_wdata,
   input  wire [3:0]  s_axi_wstrb,
   input  wire        s_axi_wvalid,
   output wire        s_axi_wready,
   output reg  [1:0]  s_axi_bresp,
   output reg         s_axi_bvalid,
   input  wire        s_axi_bready,
   input  wire [11:0] s_axi_araddr,
   input  wire        s_axi_arvalid,
   output wire        s_axi_arready,
   output reg  [31:0] s_axi_rdata,
   output reg  [1:0]  s_axi_rresp,
   output reg         s_axi_rvalid,
   input  wire        s_axi_rready,
   input  wire        transmit_delimiter_pulse_event,
   input  wire        receive_delimiter_pulse_event,
   input  wire        link_up,
   input  wire        speed_gig,
   input  wire        gig_master,
   input  wire [3:0]  align_skew,
   output reg         soft_link_restart,
   output reg  [3:0]  gpio_out,
   output wire [3:0]  gpio_oe_n
);
   // Phase counts in 40 ns clock cycles; each 8 ns step is a fraction of that, so steps round up.
   localparam integer STEPS_PER_CLK = `SFDP_CLK_NS / `SFDP_STEP_NS;
   localparam integer DLY_W = 6;

   reg  [15:0] ctrl_r, sync_r, receive_feature_config_r, mux1_r, mux2_r, phase_r, skew_r;
   reg  [1:0]  tx_s_r, rx_s_r, lk_s_r;
   reg  [2:0]  tx_q_r, rx_q_r;
   reg  [1:0]  lk_q_r;
   reg         sync_ok_r, skew_ok_r;
   reg  [3:0]  align_lat_r;
   reg  [DLY_W-1:0] tx_cnt_r, rx_cnt_r;
   reg         tx_pulse_r, rx_pulse_r;
   reg         aw_got_r, w_got_r;
   reg  [9:0]  aw_idx_r;
   reg  [31:0] w_data_r;
   reg  [3:0]  w_strb_r;
   wire        tx_edge = tx_q_r[1] & ~tx_q_r[2];
   wire        rx_edge = rx_q_r[1] & ~rx_q_r[2];
   wire        link_rise = lk_q_r[0] & ~lk_q_r[1];
   wire        wr_go = aw_got_r & w_got_r & ~s_axi_bvalid;
   wire        wr_ok = wr_go & is_mapped_w(aw_idx_r);
   wire [DLY_W-1:0] tx_dly;
   wire [DLY_W-1:0] rx_dly;

   function is_mapped_w;
      input [9:0] idx;
      begin
         is_mapped_w = (idx == `SFDP_IDX_CTRL) || (idx == `SFDP_IDX_SYNCFIFO) || (idx == `SFDP_IDX_RECEIVE_FEATURE_CONFIG) ||
                       (idx == `SFDP_IDX_MUX1) || (idx == `SFDP_IDX_MUX2) || (idx == `SFDP_IDX_PHASE);
      end
   endfunction

   // Converts an 8 ns step count into whole clock cycles, rounding up.
   function [DLY_W-1:0] steps_to_cyc;
      input [7:0] steps;
      reg   [8:0] sum;
      reg   [8:0] quo;
      begin
         sum = {1'b0, steps} + STEPS_PER_CLK[8:0] - 9'h001;
         quo = sum / STEPS_PER_CLK[8:0];
         steps_to_cyc = quo[DLY_W-1:0];
      end
   endfunction

   function [15:0] merge16;
      input [15:0] old;
      input [31:0] d;
      input [3:0]  be;
      begin
         merge16 = {be[1] ? d[15:8] : old[15:8], be[0] ? d[7:0] : old[7:0]};
      end
   endfunction

   function [3:0] pin_sel;
      input [15:0] m1;
      input [15:0] m2;
      input integer p;
      begin
         case (p)
            0: pin_sel = m1[3:0];
            1: pin_sel = m1[7:4];
            2: pin_sel = m2[3:0];
            default: pin_sel = m2[7:4];
         endcase
      end
   endfunction

   assign tx_dly = steps_to_cyc(phase_r[7:0]);
   assign rx_dly = steps_to_cyc(phase_r[15:8] + {4'h0, align_lat_r});

   // Pin inputs pass two flip-flops; only the second stage is read.
   always @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         tx_s_r <= 2'b00;
         rx_s_r <= 2'b00;
         lk_s_r <= 2'b00;
         tx_q_r <= 3'b000;
         rx_q_r <= 3'b000;
         lk_q_r <= 2'b00;
      end else if (clk_en) begin
         tx_s_r <= {tx_s_r[0], transmit_delimiter_pulse_event};
         rx_s_r <= {rx_s_r[0], receive_delimiter_pulse_event};
         lk_s_r <= {lk_s_r[0], link_up};
         tx_q_r <= {tx_q_r[1], tx_q_r[0], tx_s_r[1]};
         rx_q_r <= {rx_q_r[1], rx_q_r[0], rx_s_r[1]};
         lk_q_r <= {lk_q_r[0], lk_s_r[1]};
      end
   end

   // Alignment amount and skew readout are latched once per link so they stay constant.
   always @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         align_lat_r <= 4'h0;
         skew_r      <= `SFDP_RST_16;
         skew_ok_r   <= 1'b0;
      end else if (clk_en) begin
         if (!lk_q_r[0]) begin
            skew_ok_r <= 1'b0;
         end else if (link_rise) begin
            align_lat_r <= speed_gig ? align_skew : 4'h0;
            skew_ok_r   <= speed_gig & sync_ok_r;
            if (speed_gig && sync_ok_r) begin
               skew_r <= `SFDP_RST_16;
               if (gig_master)
                  skew_r[`SFDP_SKEW_MS_HI:`SFDP_SKEW_MS_LO] <= align_skew;
               else
                  skew_r[`SFDP_SKEW_SL_HI:`SFDP_SKEW_SL_LO] <= align_skew;
            end
         end
      end
   end

   // One-cycle delayed pulses per delimiter; a new delimiter restarts the delay.
   always @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         tx_cnt_r   <= {DLY_W{1'b0}};
         rx_cnt_r   <= {DLY_W{1'b0}};
         tx_pulse_r <= 1'b0;
         rx_pulse_r <= 1'b0;
      end else if (clk_en) begin
         tx_pulse_r <= 1'b0;
         rx_pulse_r <= 1'b0;
         if (tx_edge) begin
            if (tx_dly == {DLY_W{1'b0}})
               tx_pulse_r <= 1'b1;
            else
               tx_cnt_r <= tx_dly;
         end else if (tx_cnt_r != {DLY_W{1'b0}}) begin
            tx_cnt_r <= tx_cnt_r - {{(DLY_W-1){1'b0}}, 1'b1};
            if (tx_cnt_r == {{(DLY_W-1){1'b0}}, 1'b1})
               tx_pulse_r <= 1'b1;
         end
         if (rx_edge) begin
            if (rx_dly == {DLY_W{1'b0}})
               rx_pulse_r <= 1'b1;
            else
               rx_cnt_r <= rx_dly;
         end else if (rx_cnt_r != {DLY_W{1'b0}}) begin
            rx_cnt_r <= rx_cnt_r - {{(DLY_W-1){1'b0}}, 1'b1};
            if (rx_cnt_r == {{(DLY_W-1){1'b0}}, 1'b1})
               rx_pulse_r <= 1'b1;
         end
      end
   end

   // Pin routing; pins are driven only while the extended MAC bit is set.
   integer p;
   always @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         gpio_out <= 4'h0;
      end else if (clk_en) begin
         for (p = 0; p < `SFDP_PINS; p = p + 1) begin
            case (pin_sel(mux1_r, mux2_r, p))
               `SFDP_SEL_TX: gpio_out[p] <= tx_pulse_r & receive_feature_config_r[`SFDP_BIT_EXTMAC];
               `SFDP_SEL_RX: gpio_out[p] <= rx_pulse_r & receive_feature_config_r[`SFDP_BIT_EXTMAC];
               default:      gpio_out[p] <= 1'b0;
            endcase
         end
      end
   end

   genvar g;
   generate
      for (g = 0; g < `SFDP_PINS; g = g + 1) begin : oe
         assign gpio_oe_n[g] = ~(receive_feature_config_r[`SFDP_BIT_EXTMAC] && pin_sel(mux1_r, mux2_r, g) != `SFDP_SEL_NONE);
      end
   endgenerate

   // AXI4-Lite write side: address and data taken in either order, one write at a time.
   assign s_axi_awready = ~aw_got_r & ~s_axi_bvalid;
   assign s_axi_wready  = ~w_got_r & ~s_axi_bvalid;
   always @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         aw_got_r          <= 1'b0;
         w_got_r           <= 1'b0;
         aw_idx_r          <= 10'h000;
         w_data_r          <= 32'h00000000;
         w_strb_r          <= 4'h0;
         s_axi_bvalid      <= 1'b0;
         s_axi_bresp       <= `SFDP_RESP_OKAY;
         ctrl_r            <= `SFDP_RST_16;
         sync_r            <= `SFDP_RST_16;
         receive_feature_config_r           <= `SFDP_RST_16;
         mux1_r            <= `SFDP_RST_16;
         mux2_r            <= `SFDP_RST_16;
         phase_r           <= `SFDP_RST_16;
         sync_ok_r         <= 1'b0;
         soft_link_restart <= 1'b0;
      end else if (clk_en) begin
         soft_link_restart <= 1'b0;
         if (s_axi_awvalid && s_axi_awready) begin
            aw_got_r <= 1'b1;
            aw_idx_r <= s_axi_awaddr[11:2];
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_got_r  <= 1'b1;
            w_data_r <= s_axi_wdata;
            w_strb_r <= s_axi_wstrb;
         end
         if (s_axi_bvalid && s_axi_bready)
            s_axi_bvalid <= 1'b0;
         if (wr_go) begin
            aw_got_r     <= 1'b0;
            w_got_r      <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_ok ? `SFDP_RESP_OKAY : `SFDP_RESP_SLVERR;
            case (aw_idx_r)
               `SFDP_IDX_CTRL: begin
                  ctrl_r <= merge16(ctrl_r, w_data_r, w_strb_r) & ~(16'h0001 << `SFDP_BIT_RESTART);
                  soft_link_restart <= w_strb_r[1] & w_data_r[`SFDP_BIT_RESTART];
               end
               `SFDP_IDX_SYNCFIFO: begin
                  sync_r    <= merge16(sync_r, w_data_r, w_strb_r);
                  sync_ok_r <= merge16(sync_r, w_data_r, w_strb_r) == `SFDP_SYNC_MAGIC;
               end
               `SFDP_IDX_RECEIVE_FEATURE_CONFIG: receive_feature_config_r <= merge16(receive_feature_config_r, w_data_r, w_strb_r);
               `SFDP_IDX_MUX1:  mux1_r  <= merge16(mux1_r, w_data_r, w_strb_r);
               `SFDP_IDX_MUX2:  mux2_r  <= merge16(mux2_r, w_data_r, w_strb_r);
               `SFDP_IDX_PHASE: phase_r <= merge16(phase_r, w_data_r, w_strb_r);
               default: ;
            endcase
         end
      end
   end

   // AXI4-Lite read side; the skew register ignores writes and answers SLVERR to them.
   assign s_axi_arready = ~s_axi_rvalid;
   always @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h00000000;
         s_axi_rresp  <= `SFDP_RESP_OKAY;
      end else if (clk_en) begin
         if (s_axi_rvalid && s_axi_rready)
            s_axi_rvalid <= 1'b0;
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= `SFDP_RESP_OKAY;
            case (s_axi_araddr[11:2])
               `SFDP_IDX_CTRL:     s_axi_rdata <= {16'h0000, ctrl_r};
               `SFDP_IDX_SKEW:     s_axi_rdata <= {16'h0000, skew_r};
               `SFDP_IDX_SYNCFIFO: s_axi_rdata <= {16'h0000, sync_r};
               `SFDP_IDX_RECEIVE_FEATURE_CONFIG:    s_axi_rdata <= {16'h0000, receive_feature_config_r};
               `SFDP_IDX_MUX1:     s_axi_rdata <= {16'h0000, mux1_r};
               `SFDP_IDX_MUX2:     s_axi_rdata <= {16'h0000, mux2_r};
               `SFDP_IDX_PHASE:    s_axi_rdata <= {16'h0000, phase_r};
               `SFDP_IDX_STATUS:   s_axi_rdata <= {28'h0000000, skew_ok_r, sync_ok_r, lk_q_r[0], speed_gig};
               default: begin
                  s_axi_rdata <= 32'h00000000;
                  s_axi_rresp <= `SFDP_RESP_SLVERR;
               end
            endcase
         end
      end
   end
endmodule

// ### sfdp_checker_properties.sv
`timescale 1ns/1ns
module sfdp_checker (
   input wire        clk_sys,
   input wire        resetn,
   input wire        clk_en,
   input wire        s_axi_awvalid,
   input wire        s_axi_awready,
   input wire        s_axi_wvalid,
   input wire        s_axi_wready,
   input wire [1:0]  s_axi_bresp,
   input wire        s_axi_bvalid,
   input wire        s_axi_bready,
   input wire        s_axi_arvalid,
   input wire        s_axi_arready,
   input wire [31:0] s_axi_rdata,
   input wire        s_axi_rvalid,
   input wire        s_axi_rready,
   input wire        soft_link_restart,
   input wire [3:0]  gpio_out,
   input wire [3:0]  gpio_oe_n
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!resetn);
   a_pulse_single: assert property ((gpio_out & $past(gpio_out)) == 4'h0)
      else $error("Pin pulse longer than one cycle.");
   a_restart_once: assert property (soft_link_restart |=> !soft_link_restart)
      else $error("Restart pulse longer than one cycle.");
   a_oe_on_commit: assert property (!$stable(gpio_oe_n) |-> s_axi_bvalid && !$past(s_axi_bvalid))
      else $error("Pin enables changed outside a register write.");
   a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("Write response dropped early.");
   a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("Read data dropped early.");
   a_write_answer: assert property (clk_en && s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |-> ##[1:2] s_axi_bvalid) else $error("No write response.");
   a_read_answer: assert property (clk_en && s_axi_arvalid && s_axi_arready |-> ##[1:2] s_axi_rvalid)
      else $error("No read response.");
   a_busy_refuse: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("Write accepted while a response is pending.");
endmodule
bind sfdp_top sfdp_checker chk (.*);

// ### sfdp_mac_model.sv
`timescale 1ns/1ns
module sfdp_mac_model (
   input wire        clk_sys,
   input wire [3:0]  gpio_out,
   output logic      transmit_delimiter_pulse_event,
   output logic      receive_delimiter_pulse_event
);
   initial {transmit_delimiter_pulse_event, receive_delimiter_pulse_event} = 2'h0;
   // The event is held until the pin answers or for 40 cycles at most, so the task returns even when no pulse comes out.
   task automatic fire(input int pin, output int lat);
      lat = 0;
      @(posedge clk_sys);
      if (pin == 0) transmit_delimiter_pulse_event <= 1'h1;
      else receive_delimiter_pulse_event <= 1'h1;
      do begin
         @(posedge clk_sys);
         lat++;
         #1;
      end while (gpio_out[pin] !== 1'h1 && lat < 40);
      {transmit_delimiter_pulse_event, receive_delimiter_pulse_event} <= 2'h0;
   endtask
endmodule

// ### test_sfdp_top.sv
`timescale 1ns/1ns
`include "sfdp_map.vh"
module test_sfdp_top;
   logic        clk_sys = 1'h0, resetn = 1'h0, link_up = 1'h0, speed_gig = 1'h0, gig_master = 1'h0;
   logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
   logic [31:0] s_axi_wdata = 32'h0;
   logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0, s_axi_arvalid = 1'h0;
   logic        s_axi_rready = 1'h0, clk_en = 1'h1;
   logic [3:0]  align_skew = 4'h0;
   wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   wire         transmit_delimiter_pulse_event, receive_delimiter_pulse_event, soft_link_restart;
   wire [1:0]   s_axi_bresp, s_axi_rresp;
   wire [31:0]  s_axi_rdata;
   wire [3:0]   gpio_out, gpio_oe_n;
   int          fails = 0, n_checks = 0, n_rst = 0, lat;
   // Two synchroniser stages, two edge stages, the pulse flop and the pin flop.
   localparam int PIN_LAT = 6;
   always #20 clk_sys = ~clk_sys;
   sfdp_top dut (.s_axi_wstrb(4'hF), .*);
   sfdp_mac_model mac (.*);
   always @(posedge clk_sys) if (soft_link_restart === 1'h1) n_rst <= n_rst + 1;
   task automatic conclude;
      $display("Checks %0d, mismatches %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      n_checks++;
      if (g !== e) begin
         fails++;
         $display("Error at %0t: got %h, expected %h", $time, g, e);
      end
   endtask
   // Ready is raised late on purpose so the slave must hold its answer for a cycle.
   task automatic wr(input logic [9:0] idx, input logic [15:0] d, input logic [1:0] er);
      int n;
      n = 0;
      @(posedge clk_sys);
      s_axi_awaddr <= {idx, 2'h0};
      s_axi_wdata <= {16'h0000, d};
      {s_axi_awvalid, s_axi_wvalid} <= 2'h3;
      do begin
         @(posedge clk_sys);
         n++;
         if (s_axi_awready === 1'h1) s_axi_awvalid <= 1'h0;
         if (s_axi_wready === 1'h1) s_axi_wvalid <= 1'h0;
         if (n == 3) s_axi_bready <= 1'h1;
      end while (!(s_axi_bvalid === 1'h1 && s_axi_bready === 1'h1));
      s_axi_bready <= 1'h0;
      chk({30'h0, s_axi_bresp}, {30'h0, er});
   endtask
   task automatic rd(input logic [9:0] idx, input logic [31:0] e, input logic [1:0] er);
      int n;
      n = 0;
      @(posedge clk_sys);
      s_axi_araddr <= {idx, 2'h0};
      s_axi_arvalid <= 1'h1;
      do begin
         @(posedge clk_sys);
         n++;
         if (s_axi_arready === 1'h1) s_axi_arvalid <= 1'h0;
         if (n == 3) s_axi_rready <= 1'h1;
      end while (!(s_axi_rvalid === 1'h1 && s_axi_rready === 1'h1));
      s_axi_rready <= 1'h0;
      chk(s_axi_rdata, e);
      chk({30'h0, s_axi_rresp}, {30'h0, er});
   endtask
   task automatic lnk(input logic up);
      @(posedge clk_sys);
      link_up <= up;
      repeat (6) @(posedge clk_sys);
   endtask
   task automatic pulse(input int pin, input int e);
      mac.fire(pin, lat);
      chk(lat, e);
   endtask
   initial begin
      #400000;
      fails++;
      conclude;
   end
   initial begin
      repeat (20) @(posedge clk_sys);
      resetn <= 1'h1;
      wr(`SFDP_IDX_RECEIVE_FEATURE_CONFIG, 16'h0080, `SFDP_RESP_OKAY);
      wr(`SFDP_IDX_MUX1, 16'h0021, `SFDP_RESP_OKAY);
      chk({28'h0, gpio_oe_n}, 32'h0000000C);
      rd(`SFDP_IDX_MUX1, 32'h00000021, `SFDP_RESP_OKAY);
      wr(`SFDP_IDX_SKEW, 16'h00FF, `SFDP_RESP_SLVERR);
      rd(10'h3FF, 32'h0, `SFDP_RESP_SLVERR);
      $display("Register test done");
      pulse(0, PIN_LAT);
      pulse(1, PIN_LAT);
      wr(`SFDP_IDX_PHASE, 16'h000A, `SFDP_RESP_OKAY);
      pulse(0, PIN_LAT + 2);
      $display("Pulse test done");
      {speed_gig, gig_master, align_skew} <= 6'h33;
      lnk(1'h1);
      rd(`SFDP_IDX_SKEW, 32'h0, `SFDP_RESP_OKAY);
      lnk(1'h0);
      wr(`SFDP_IDX_SYNCFIFO, `SFDP_SYNC_MAGIC, `SFDP_RESP_OKAY);
      lnk(1'h1);
      rd(`SFDP_IDX_SKEW, 32'h00000030, `SFDP_RESP_OKAY);
      align_skew <= 4'hF;
      pulse(1, PIN_LAT + 1);
      rd(`SFDP_IDX_SKEW, 32'h00000030, `SFDP_RESP_OKAY);
      lnk(1'h0);
      {gig_master, align_skew} <= 5'h02;
      lnk(1'h1);
      rd(`SFDP_IDX_SKEW, 32'h00000002, `SFDP_RESP_OKAY);
      pulse(1, PIN_LAT + 1);
      lnk(1'h0);
      speed_gig <= 1'h0;
      lnk(1'h1);
      rd(`SFDP_IDX_SKEW, 32'h00000002, `SFDP_RESP_OKAY);
      pulse(1, PIN_LAT);
      $display("Skew test done");
      wr(`SFDP_IDX_CTRL, 16'h4000, `SFDP_RESP_OKAY);
      chk(n_rst, 1);
      rd(`SFDP_IDX_CTRL, 32'h0, `SFDP_RESP_OKAY);
      // The model gives up after 40 cycles, so a latency of 40 means no pulse came out.
      clk_en <= 1'h0;
      pulse(0, 40);
      clk_en <= 1'h1;
      pulse(0, PIN_LAT + 2);
      wr(`SFDP_IDX_RECEIVE_FEATURE_CONFIG, 16'h0000, `SFDP_RESP_OKAY);
      chk({28'h0, gpio_oe_n}, 32'h0000000F);
      pulse(0, 40);
      $display("Control test done");
      conclude;
   end
endmodule
